// file: core/sbwpl_regs.sv
// Register bank for the control-channel watchdog, back-channel CRC error count and PLL source.
// Assumes a byte-wide register port from the serial management slave, synchronous to core_clk,
// with one-cycle read and write strobes; the global override bit arrives as a level.
`timescale 1ns/1ps

// How it works
// - The timeout is bits 7:1 of the watchdog register times 2 ms, 0 counting as 128, reset value 0x7f.
// - Watchdog bit 0 set to 1 stops the watchdog, 0 lets it run, and it resets to 0.
// - A read-only 8-bit count of back-channel CRC errors in self-test, reset to zero.
// - PLL register bit 3 shows whether the mode strap selects external oscillator mode.
// - With override set, bit 0 at 1 feeds the internal oscillator to the PLL; it resets to 1.
// - With override set and bit 0 clear, bit 1 picks the external pin, else pixel clock.
module sbwpl_regs #(
   parameter int WDOG_STEP_CYCLES = sbwpl_pkg::WDOG_STEP_CYCLES
) (
   input  wire logic        core_clk,
   input  wire logic        reset,
   input  wire logic        ce,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   output logic             reg_rvalid,
   input  wire logic        bcc_txn_start,
   input  wire logic        bcc_txn_done,
   output logic             bcc_txn_abort,
   output logic             bcc_busy,
   input  wire logic        selftest_active,
   input  wire logic        bc_crc_err,
   input  wire logic        pll_source_override,
   input  wire logic        strap_ext_osc_mode,
   output logic      [1:0]  pll_ref_sel
);

   sbwpl_wdog_if wd_if ();

   logic [6:0]  wd_tmo_r, wd_tmo_nxt;
   logic        wd_off_r, wd_off_nxt;
   logic [7:0]  crc_cnt_r, crc_cnt_nxt;
   logic        osc_bit_r, osc_bit_nxt;
   logic        ext_bit_r, ext_bit_nxt;
   logic        strap_r, strap_nxt;
   logic        strap_taken_r, strap_taken_nxt;
   logic [1:0]  ref_sel_r, ref_sel_nxt;
   logic [7:0]  rdata_r, rdata_nxt;
   logic        rvalid_r, rvalid_nxt;
   logic        wr_wdog;
   logic        wr_pll;

   // Write decode
   always_comb begin
      wr_wdog = 1'b0;
      wr_pll  = 1'b0;
      if (reg_wr && reg_addr == sbwpl_pkg::ADDR_WDOG) begin
         wr_wdog = 1'b1;
      end else if (reg_wr && reg_addr == sbwpl_pkg::ADDR_PLL) begin
         wr_pll = 1'b1;
      end
   end

   // Next values of the writable controls
   always_comb begin
      wd_tmo_nxt  = wd_tmo_r;
      wd_off_nxt  = wd_off_r;
      osc_bit_nxt = osc_bit_r;
      ext_bit_nxt = ext_bit_r;
      if (wr_wdog) begin
         wd_tmo_nxt = reg_wdata[sbwpl_pkg::WDOG_TMO_MSB:sbwpl_pkg::WDOG_TMO_LSB];
         wd_off_nxt = reg_wdata[sbwpl_pkg::WDOG_OFF_BIT];
      end
      if (wr_pll) begin
         osc_bit_nxt = reg_wdata[sbwpl_pkg::PLL_OSC_BIT];
         ext_bit_nxt = reg_wdata[sbwpl_pkg::PLL_EXT_BIT];
      end
   end

   // Control registers
   always_ff @(posedge core_clk) begin
      if (reset) begin
         wd_tmo_r  <= sbwpl_pkg::WDOG_TMO_RST;
         wd_off_r  <= sbwpl_pkg::WDOG_OFF_RST;
         osc_bit_r <= sbwpl_pkg::PLL_OSC_RST;
         ext_bit_r <= sbwpl_pkg::PLL_EXT_RST;
      end else if (ce) begin
         wd_tmo_r  <= wd_tmo_nxt;
         wd_off_r  <= wd_off_nxt;
         osc_bit_r <= osc_bit_nxt;
         ext_bit_r <= ext_bit_nxt;
      end
   end

   // Saturating CRC error count, only while self-test runs
   always_comb begin
      crc_cnt_nxt = crc_cnt_r;
      if (selftest_active && bc_crc_err && crc_cnt_r != sbwpl_pkg::CRC_CNT_MAX) begin
         crc_cnt_nxt = crc_cnt_r + 8'h01;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         crc_cnt_r <= sbwpl_pkg::CRC_CNT_RST;
      end else if (ce) begin
         crc_cnt_r <= crc_cnt_nxt;
      end
   end

   // Strap is caught once on the first enabled cycle after reset release
   always_comb begin
      strap_nxt       = strap_r;
      strap_taken_nxt = 1'b1;
      if (!strap_taken_r) begin
         strap_nxt = strap_ext_osc_mode;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         strap_r       <= 1'b0;
         strap_taken_r <= 1'b0;
      end else if (ce) begin
         strap_r       <= strap_nxt;
         strap_taken_r <= strap_taken_nxt;
      end
   end

   // PLL reference choice
   always_comb begin
      if (pll_source_override) begin
         if (osc_bit_r) begin
            ref_sel_nxt = sbwpl_pkg::SBWPL_REF_OSC;
         end else if (ext_bit_r) begin
            ref_sel_nxt = sbwpl_pkg::SBWPL_REF_EXT;
         end else begin
            ref_sel_nxt = sbwpl_pkg::SBWPL_REF_PIXEL;
         end
      end else if (strap_r) begin
         ref_sel_nxt = sbwpl_pkg::SBWPL_REF_EXT;
      end else begin
         ref_sel_nxt = sbwpl_pkg::SBWPL_REF_PIXEL;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         ref_sel_r <= sbwpl_pkg::SBWPL_REF_PIXEL;
      end else if (ce) begin
         ref_sel_r <= ref_sel_nxt;
      end
   end

   // Read mux; unmapped offsets and reserved bits read as zero
   always_comb begin
      rdata_nxt  = rdata_r;
      rvalid_nxt = reg_rd;
      if (reg_rd) begin
         if (reg_addr == sbwpl_pkg::ADDR_WDOG) begin
            rdata_nxt = {wd_tmo_r, wd_off_r};
         end else if (reg_addr == sbwpl_pkg::ADDR_CRC) begin
            rdata_nxt = crc_cnt_r;
         end else if (reg_addr == sbwpl_pkg::ADDR_PLL) begin
            rdata_nxt = {4'h0, strap_r, 1'b0, ext_bit_r, osc_bit_r};
         end else begin
            rdata_nxt = 8'h00;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         rdata_r  <= 8'h00;
         rvalid_r <= 1'b0;
      end else if (ce) begin
         rdata_r  <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
      end
   end

   // Watchdog hookup
   assign wd_if.txn_start = bcc_txn_start;
   assign wd_if.txn_done  = bcc_txn_done;
   assign wd_if.timeout   = wd_tmo_r;
   assign wd_if.wd_off    = wd_off_r;

   sbwpl_wdog #(
      .STEP_CYCLES (WDOG_STEP_CYCLES)
   ) u_wdog (
      .core_clk (core_clk),
      .reset    (reset),
      .ce       (ce),
      .wd       (wd_if.tmr)
   );

   assign bcc_txn_abort = wd_if.abort;
   assign bcc_busy      = wd_if.busy;
   assign reg_rdata     = rdata_r;
   assign reg_rvalid    = rvalid_r;
   assign pll_ref_sel   = ref_sel_r;

   a_crc_saturates: assert property (@(posedge core_clk) disable iff (reset)
      crc_cnt_r == sbwpl_pkg::CRC_CNT_MAX |=> crc_cnt_r == sbwpl_pkg::CRC_CNT_MAX)
      else $error("CRC count wrapped");

   a_crc_counts_up: assert property (@(posedge core_clk) disable iff (reset)
      ce && selftest_active && bc_crc_err && crc_cnt_r != sbwpl_pkg::CRC_CNT_MAX
      |=> crc_cnt_r == $past(crc_cnt_r) + 8'h01)
      else $error("CRC error not counted");

   a_crc_needs_test: assert property (@(posedge core_clk) disable iff (reset)
      !(selftest_active && bc_crc_err) |=> $stable(crc_cnt_r))
      else $error("CRC count moved outside self-test");

   a_osc_selected: assert property (@(posedge core_clk) disable iff (reset)
      ce && pll_source_override && osc_bit_r |=> ref_sel_r == sbwpl_pkg::SBWPL_REF_OSC)
      else $error("Oscillator not selected");

   a_ext_selected: assert property (@(posedge core_clk) disable iff (reset)
      ce && pll_source_override && !osc_bit_r
      |=> ref_sel_r == ($past(ext_bit_r) ? sbwpl_pkg::SBWPL_REF_EXT : sbwpl_pkg::SBWPL_REF_PIXEL))
      else $error("Wrong override reference");

   a_strap_selects: assert property (@(posedge core_clk) disable iff (reset)
      ce && !pll_source_override
      |=> ref_sel_r == ($past(strap_r) ? sbwpl_pkg::SBWPL_REF_EXT : sbwpl_pkg::SBWPL_REF_PIXEL))
      else $error("Strap reference not used");

   a_strap_readback: assert property (@(posedge core_clk) disable iff (reset)
      ce && reg_rd && reg_addr == sbwpl_pkg::ADDR_PLL
      |=> reg_rvalid && reg_rdata[3] == $past(strap_r))
      else $error("Strap status misread");

   a_wdog_defaults: assert property (@(posedge core_clk)
      $fell(reset) |-> wd_tmo_r == sbwpl_pkg::WDOG_TMO_RST && !wd_off_r && osc_bit_r)
      else $error("Bad reset values");

   c_crc_full: cover property (@(posedge core_clk) disable iff (reset)
      crc_cnt_r == sbwpl_pkg::CRC_CNT_MAX);
   c_ext_ref: cover property (@(posedge core_clk) disable iff (reset)
      ref_sel_r == sbwpl_pkg::SBWPL_REF_EXT);
   c_wdog_off_write: cover property (@(posedge core_clk) disable iff (reset)
      wr_wdog && reg_wdata[0]);

endmodule // sbwpl_regs

// file: core/sbwpl_pkg.sv
// Constants, field layouts and types shared by the watchdog, error count and PLL source bank.
// Assumes an 8-bit register port with one byte per printed offset and a 50 MHz core clock.
package sbwpl_pkg;

   // Register offsets
   localparam logic [7:0] ADDR_WDOG = 8'h1e;
   localparam logic [7:0] ADDR_CRC  = 8'h2a;
   localparam logic [7:0] ADDR_PLL  = 8'h35;

   // Watchdog control fields
   localparam int WDOG_TMO_LSB = 1;
   localparam int WDOG_TMO_MSB = 7;
   localparam int WDOG_OFF_BIT = 0;

   // PLL clock source override fields
   localparam int PLL_OSC_BIT   = 0;
   localparam int PLL_EXT_BIT   = 1;
   localparam int PLL_STRAP_BIT = 3;

   // Reset values and the CRC count limit
   localparam logic [6:0] WDOG_TMO_RST = 7'h7f;
   localparam logic       WDOG_OFF_RST = 1'b0;
   localparam logic [7:0] CRC_CNT_RST  = 8'h00;
   localparam logic [7:0] CRC_CNT_MAX  = 8'hff;
   localparam logic       PLL_OSC_RST  = 1'b1;
   localparam logic       PLL_EXT_RST  = 1'b0;

   // Timing: one watchdog step is 2 ms
   localparam int CLK_HZ            = 50_000_000;
   localparam int WDOG_STEP_MS      = 2;
   localparam int WDOG_STEP_CYCLES  = WDOG_STEP_MS * (CLK_HZ / 1000);
   localparam int WDOG_PRE_W        = 17;

   // PLL reference choices
   typedef enum logic [1:0] {
      SBWPL_REF_PIXEL = 2'b00,
      SBWPL_REF_OSC   = 2'b01,
      SBWPL_REF_EXT   = 2'b10
   } sbwpl_ref_t;

   // Watchdog states
   typedef enum logic {
      SBWPL_WD_IDLE = 1'b0,
      SBWPL_WD_RUN  = 1'b1
   } sbwpl_wd_state_t;

endpackage

// file: core/sbwpl_wdog_if.sv
// Signals between the register bank and its control-channel watchdog.
// Assumes both ends share core_clk.
`timescale 1ns/1ps
interface sbwpl_wdog_if;
   logic       txn_start;
   logic       txn_done;
   logic [6:0] timeout;
   logic       wd_off;
   logic       abort;
   logic       busy;

   // Register bank side
   modport ctl (output txn_start, output txn_done, output timeout, output wd_off,
                input abort, input busy);
   // Timer side
   modport tmr (input txn_start, input txn_done, input timeout, input wd_off,
                output abort, output busy);
endinterface

// file: core/sbwpl_wdog.sv
// Control-channel watchdog timer: counts 2 ms steps while a transaction is open.
// Assumes start and done are one-cycle pulses synchronous to core_clk.
`timescale 1ns/1ps
module sbwpl_wdog #(
   parameter int STEP_CYCLES = sbwpl_pkg::WDOG_STEP_CYCLES
) (
   input  wire logic  core_clk,
   input  wire logic  reset,
   input  wire logic  ce,
   sbwpl_wdog_if.tmr  wd
);
   localparam logic [sbwpl_pkg::WDOG_PRE_W-1:0] PRE_LAST =
      sbwpl_pkg::WDOG_PRE_W'(STEP_CYCLES - 1);

   sbwpl_pkg::sbwpl_wd_state_t             state_r, state_nxt;
   logic [sbwpl_pkg::WDOG_PRE_W-1:0]       pre_r, pre_nxt;
   logic [6:0]                             steps_r, steps_nxt;
   logic                                   abort_r, abort_nxt;

   // Next state of the timer
   always_comb begin
      state_nxt = state_r;
      pre_nxt   = pre_r;
      steps_nxt = steps_r;
      abort_nxt = 1'b0;
      if (wd.wd_off) begin
         state_nxt = sbwpl_pkg::SBWPL_WD_IDLE;
         pre_nxt   = '0;
         steps_nxt = '0;
      end else begin
         case (state_r)
            sbwpl_pkg::SBWPL_WD_IDLE: begin
               if (wd.txn_start) begin
                  state_nxt = sbwpl_pkg::SBWPL_WD_RUN;
                  pre_nxt   = '0;
                  steps_nxt = '0;
               end
            end
            sbwpl_pkg::SBWPL_WD_RUN: begin
               if (wd.txn_done) begin
                  state_nxt = sbwpl_pkg::SBWPL_WD_IDLE;
               end else if (wd.txn_start) begin
                  pre_nxt   = '0;
                  steps_nxt = '0;
               end else if (pre_r == PRE_LAST) begin
                  pre_nxt   = '0;
                  steps_nxt = steps_r + 7'h01;
                  if (steps_r + 7'h01 == wd.timeout) begin
                     abort_nxt = 1'b1;
                     state_nxt = sbwpl_pkg::SBWPL_WD_IDLE;
                  end
               end else begin
                  pre_nxt = pre_r + 1'b1;
               end
            end
            default: state_nxt = sbwpl_pkg::SBWPL_WD_IDLE;
         endcase
      end
   end

   // Timer registers, frozen while ce is low
   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_r <= sbwpl_pkg::SBWPL_WD_IDLE;
         pre_r   <= '0;
         steps_r <= '0;
         abort_r <= 1'b0;
      end else if (ce) begin
         state_r <= state_nxt;
         pre_r   <= pre_nxt;
         steps_r <= steps_nxt;
         abort_r <= abort_nxt;
      end
   end

   assign wd.abort = abort_r;
   assign wd.busy  = (state_r == sbwpl_pkg::SBWPL_WD_RUN);

   // Abort comes only from a running timer at a step boundary
   a_abort_from_run: assert property (@(posedge core_clk) disable iff (reset)
      $rose(abort_r) |-> $past(state_r == sbwpl_pkg::SBWPL_WD_RUN && pre_r == PRE_LAST))
      else $error("Abort without running timer at step end");

   a_off_no_abort: assert property (@(posedge core_clk) disable iff (reset)
      ce && wd.wd_off |=> !abort_r && state_r == sbwpl_pkg::SBWPL_WD_IDLE)
      else $error("Watchdog acted while disabled");

   a_done_stops_timer: assert property (@(posedge core_clk) disable iff (reset)
      ce && !wd.wd_off && wd.txn_done && state_r == sbwpl_pkg::SBWPL_WD_RUN
      |=> state_r == sbwpl_pkg::SBWPL_WD_IDLE && !abort_r)
      else $error("Timer kept running after done");

   a_start_restart: assert property (@(posedge core_clk) disable iff (reset)
      ce && !wd.wd_off && wd.txn_start && !wd.txn_done
      |=> state_r == sbwpl_pkg::SBWPL_WD_RUN && pre_r == '0 && steps_r == '0)
      else $error("Timer did not restart on start");

   a_abort_at_timeout: assert property (@(posedge core_clk) disable iff (reset)
      $rose(abort_r) |-> steps_r == wd.timeout)
      else $error("Abort before programmed step count");

   c_abort_seen: cover property (@(posedge core_clk) disable iff (reset) $rose(abort_r));
   c_done_in_time: cover property (@(posedge core_clk) disable iff (reset)
      wd.busy && wd.txn_done && ce);

endmodule // sbwpl_wdog

// file: dv/sbwpl_peer.sv
// Far-end control-channel peer: opens a transaction and closes it after a set delay.
// Assumes core_clk is shared and go is a one-cycle pulse from the bench.
`timescale 1ns/1ps
module sbwpl_peer (
   input  wire logic       core_clk,
   input  wire logic       reset,
   input  wire logic       go,
   input  wire logic [7:0] len,
   input  wire logic       abort,
   output logic            txn_start,
   output logic            txn_done
);
   logic [7:0] cnt_r;
   logic       open_r;

   // Start on go, finish after len cycles; len of 0 stalls until aborted
   always_ff @(posedge core_clk) begin
      txn_start <= 1'b0;
      txn_done  <= 1'b0;
      if (reset) begin
         cnt_r  <= 8'h00;
         open_r <= 1'b0;
      end else if (go) begin
         txn_start <= 1'b1;
         cnt_r     <= len;
         open_r    <= (len != 8'h00);
      end else if (abort) begin
         open_r <= 1'b0; // Channel freed by the watchdog's abort
      end else if (open_r) begin
         if (cnt_r == 8'h01) begin
            txn_done <= 1'b1;
            open_r   <= 1'b0;
         end
         cnt_r <= cnt_r - 8'h01;
      end
   end
endmodule // sbwpl_peer

// file: dv/serializer_bcc_watchdog_pll_src_bench.sv
// Self-checking bench for the watchdog, error count and PLL source bank.
// Assumes a 4-cycle watchdog step and the strap at external oscillator mode until the second reset.
`timescale 1ns/1ps
module serializer_bcc_watchdog_pll_src_bench;
   logic       core_clk = 1'b0;
   logic       reset    = 1'b1;
   logic       ce       = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic       reg_rvalid;
   logic       start, done, abort, busy;
   logic       st_on = 1'b0;
   logic       crc_err = 1'b0;
   logic       ovr = 1'b0;
   logic       strap = 1'b1;
   logic [1:0] ref_sel;
   logic       go = 1'b0;
   logic [7:0] len = 8'h00;
   int         err_total = 0;
   int         n_checks = 0;
   int         cyc = 0;

   sbwpl_regs #(.WDOG_STEP_CYCLES(4)) i_sbwpl_regs (
      .core_clk(core_clk), .reset(reset), .ce(ce), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .bcc_txn_start(start), .bcc_txn_done(done),
      .bcc_txn_abort(abort), .bcc_busy(busy), .selftest_active(st_on),
      .bc_crc_err(crc_err), .pll_source_override(ovr), .strap_ext_osc_mode(strap),
      .pll_ref_sel(ref_sel));

   sbwpl_peer i_sbwpl_peer (
      .core_clk(core_clk), .reset(reset), .go(go), .len(len), .abort(abort),
      .txn_start(start), .txn_done(done));

   // 50 MHz clock
   always #10 core_clk = ~core_clk;

   // Hang guard
   always @(posedge core_clk) begin
      cyc++;
      if (cyc > 20000) begin
         err_total++;
         wrap_up();
      end
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   // Read strobe, data checked in the cycle of the valid pulse
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string w);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk("rvalid", {7'h0, reg_rvalid}, 8'h01);
      chk(w, reg_rdata, e);
   endtask

   // Set the override level and check the chosen reference
   task automatic pll(input logic ov, input logic [1:0] e);
      @(posedge core_clk);
      ovr <= ov;
      repeat (2) @(posedge core_clk);
      #1;
      chk("pll_ref_sel", {6'h0, ref_sel}, {6'h0, e});
   endtask

   task automatic launch(input logic [7:0] l);
      @(posedge core_clk);
      go  <= 1'b1;
      len <= l;
      @(posedge core_clk);
      go <= 1'b0;
   endtask

   // Open a transaction, count edges after the start is taken until an abort
   task automatic run_txn(input logic [7:0] l, input logic b, input logic [7:0] exp);
      int n;
      n = 0;
      launch(l);
      @(posedge core_clk);
      #1;
      chk("busy", {7'h0, busy}, {7'h0, b});
      while (abort !== 1'b1 && n < 40) begin
         @(posedge core_clk);
         n++;
         #1;
      end
      chk("abort edge", (n < 40) ? n[7:0] : 8'h00, exp);
      chk("busy after", {7'h0, busy}, 8'h00);
   endtask

   initial begin
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      // Reset values and an unmapped place
      rd(8'h1e, 8'hfe, "wdog reset");
      rd(8'h2a, 8'h00, "crc reset");
      rd(8'h35, 8'h09, "pll reset");
      rd(8'h20, 8'h00, "unmapped");
      // PLL reference selection
      pll(1'b0, 2'b10);
      pll(1'b1, 2'b01);
      wr(8'h35, 8'h02);
      pll(1'b1, 2'b10);
      wr(8'h35, 8'h00);
      pll(1'b1, 2'b00);
      pll(1'b0, 2'b10);
      wr(8'h35, 8'hff);
      rd(8'h35, 8'h0b, "pll bits");
      pll(1'b1, 2'b01);
      // Watchdog, timeouts of one and two steps, then disabled, never zero
      wr(8'h1e, 8'h02);
      rd(8'h1e, 8'h02, "wdog rw");
      run_txn(8'h00, 1'b1, 8'h04);
      run_txn(8'h02, 1'b1, 8'h00);
      launch(8'h00);
      run_txn(8'h00, 1'b1, 8'h04);
      wr(8'h1e, 8'h04);
      run_txn(8'h00, 1'b1, 8'h08);
      wr(8'h1e, 8'h05);
      run_txn(8'h00, 1'b0, 8'h00);
      // Error count only in self-test, read-only, saturating
      @(posedge core_clk);
      crc_err <= 1'b1;
      repeat (3) @(posedge core_clk);
      st_on <= 1'b1;
      repeat (3) @(posedge core_clk);
      crc_err <= 1'b0;
      rd(8'h2a, 8'h03, "crc count");
      // Clock enable low freezes the count even with errors flagged
      @(posedge core_clk);
      ce      <= 1'b0;
      crc_err <= 1'b1;
      repeat (3) @(posedge core_clk);
      ce      <= 1'b1;
      crc_err <= 1'b0;
      rd(8'h2a, 8'h03, "crc frozen");
      wr(8'h2a, 8'h55);
      rd(8'h2a, 8'h03, "crc ro");
      @(posedge core_clk);
      crc_err <= 1'b1;
      repeat (300) @(posedge core_clk);
      crc_err <= 1'b0;
      rd(8'h2a, 8'hff, "crc sat");
      // Second reset with the strap now at pixel mode
      @(posedge core_clk);
      reset <= 1'b1;
      strap <= 1'b0;
      ovr   <= 1'b0;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      rd(8'h1e, 8'hfe, "wdog reset 2");
      rd(8'h2a, 8'h00, "crc reset 2");
      rd(8'h35, 8'h01, "pll strap off");
      pll(1'b0, 2'b00);
      wrap_up();
   end
endmodule // serializer_bcc_watchdog_pll_src_bench
